// ---- verilog/tse_pkg.sv ----
// Purpose: shared constants and types for the timestamp packet encoder
// Assumes: byte-wide trace stream, classic Wishbone register slave
// Notes: register offsets are byte addresses on a 32-bit bus
package tse_pkg;
  localparam int TS_W = 64;
  localparam logic [7:0] HDR_BASE = 8'h42;
  localparam int HDR_R_BIT = 2;
  localparam logic [3:0] BYTES_48 = 4'h7;
  localparam logic [3:0] BYTES_64 = 4'h9;
  localparam logic [3:0] PKT_LEN_48 = 4'h8;
  localparam logic [3:0] PKT_LEN_64 = 4'hA;
  localparam logic [3:0] ADR_CTRL = 4'h0;
  localparam logic [3:0] ADR_CAP = 4'h4;
  localparam logic [3:0] ADR_STAT = 4'h8;
  localparam logic [3:0] ADR_LAST_LO = 4'hC;
  localparam int CTRL_EN_BIT = 0;
  localparam int CAP_LEN_LSB = 0;
  localparam int CAP_FMT64_BIT = 4;
  localparam int CAP_GRAY_BIT = 28;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CAP_RST = 32'h0000_0000;
  localparam logic [TS_W-1:0] LAST_RST = 64'h0;

  typedef struct packed {
    logic [3:0] adr;
    logic we;
    logic [3:0] sel;
    logic [31:0] dat;
    logic req;
  } tse_wb_req_t;

  typedef struct packed {
    logic [7:0] data;
    logic valid;
    logic last;
  } tse_byte_t;
endpackage

// ---- verilog/tse_byte_sel.sv ----
// Purpose: chooses one value byte of a timestamp packet
// Assumes: idx counts value bytes from zero, n is number of bytes sent
// Notes: purely combinational
`timescale 1ns/100ps
module tse_byte_sel
  import tse_pkg::*;
(
  input wire logic [tse_pkg::TS_W-1:0] val_i, // Value to send
  input wire logic [3:0] idx_i, // Value byte index
  input wire logic [3:0] n_i, // Bytes in packet
  input wire logic fmt64_i, // 64-bit format
  output logic [7:0] byte_o // Encoded byte
);
  logic [6:0] grp;
  logic cont;
  wire logic [TS_W+6:0] ext = {7'h00, val_i};
  wire logic [6:0] shamt = 7'(idx_i) * 7'd7;
  wire logic [TS_W+6:0] shifted = ext >> shamt;
  assign grp = shifted[6:0];
  assign cont = (idx_i + 4'h1) < n_i;
  always_comb
  begin
    // [RQ6] top byte full
    if (fmt64_i && idx_i == 4'h8)
      byte_o = val_i[63:56];
    // [RQ5] bit6 zero
    else if (!fmt64_i && idx_i == 4'h6)
      byte_o = {1'b0, 1'b0, grp[5:0]};
    // [RQ4] seven bits, continuation
    else
      byte_o = {cont, grp};
  end
endmodule

// ---- verilog/tse_encoder.sv ----
// Purpose: builds timestamp packets for a byte-oriented trace stream
// Assumes: requests, clock-change and overflow flags come from same clock
// Notes: packet goes out one byte per cycle while out_ready_i is high;
// requests seen during a packet merge into one pending packet, so bursts of
// events cost one timestamp rather than a queue of them
// Behaviour
// [RQ1] header 0b01000R10 starts each packet
// [RQ2] one to nine value bytes follow
// [RQ3] capability reports 8 or 10 bytes
// [RQ4] seven bits per byte, continuation bit7
// [RQ5] 48-bit seventh byte: C zero, SBZ
// [RQ6] 64-bit ninth byte holds bits 63:56
// [RQ7] always at least one value byte
// [RQ8] send up to top changed bit
// [RQ9] all-zero value means unknown
// [RQ10] R set on clock change since last
// [RQ11] optional Gray coding of value
// [RQ12] disabled at reset until enabled
// [RQ13] full value after overflow
// [RQ14] keep last sent value for compare
// [RQ15] full request sends all bytes
//
// Implementation choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/100ps
module tse_encoder
  import tse_pkg::*;
(
  input wire logic clk_i, // Clock, 25 MHz
  input wire logic rst_i, // Sync reset, active high
  input wire logic [31:0] wb_adr_i, // Wishbone address
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic [tse_pkg::TS_W-1:0] ts_count_i, // Shared timestamp count
  input wire logic ts_req_i, // Timestamp request pulse
  input wire logic full_req_i, // Full timestamp request pulse
  input wire logic clk_change_i, // Clock period changed pulse
  input wire logic overflow_i, // Trace overflow pulse
  input wire logic out_ready_i, // Stream sink ready
  output logic [7:0] out_data_o, // Stream byte
  output logic out_valid_o, // Stream byte valid
  output logic out_last_o, // Last byte of packet
  output logic busy_o // Packet in progress
);
  typedef enum logic [1:0] {ST_IDLE, ST_HDR, ST_VAL} tse_state_t;

  tse_state_t state_q, state_d;
  logic [31:0] ctrl_q;
  logic [31:0] cap_q;
  logic [TS_W-1:0] last_q;
  logic [TS_W-1:0] val_q;
  logic [3:0] n_q;
  logic [3:0] idx_q;
  logic r_q;
  logic pend_q;
  logic pend_full_q;
  logic chg_q;
  logic ovf_q;
  logic ack_q;
  logic [31:0] rdat_q;
  tse_byte_t out_q;
  logic busy_q;
  logic [7:0] vbyte;
  logic [TS_W-1:0] gray_val;
  logic [TS_W-1:0] samp;
  logic [TS_W-1:0] diff;
  logic [6:0] top_bit;
  logic [3:0] need;
  logic [3:0] nmax;

  // Bus decode
  tse_wb_req_t bus;
  assign bus = '{adr: wb_adr_i[3:0], we: wb_we_i, sel: wb_sel_i, dat: wb_dat_i,
                 req: wb_cyc_i & wb_stb_i & ~ack_q};
  // Upper address bits must be clear, otherwise the access is unmapped
  wire logic adr_ok = wb_adr_i[31:4] == 28'h0;
  wire logic hit_ctrl = bus.req && bus.adr == ADR_CTRL && adr_ok;
  wire logic hit_cap = bus.req && bus.adr == ADR_CAP && adr_ok;
  wire logic wr_ctrl = hit_ctrl & bus.we;
  wire logic wr_cap = hit_cap & bus.we;
  wire logic en = ctrl_q[CTRL_EN_BIT];
  wire logic fmt64 = cap_q[CAP_FMT64_BIT];
  wire logic gray_en = cap_q[CAP_GRAY_BIT];
  wire logic [31:0] sel_mask = {{8{bus.sel[3]}}, {8{bus.sel[2]}}, {8{bus.sel[1]}}, {8{bus.sel[0]}}};
  // [RQ3] length field derived from format
  wire logic [3:0] cap_len = fmt64 ? PKT_LEN_64 : PKT_LEN_48;
  wire logic [31:0] cap_rd = {3'h0, gray_en, 23'h0, fmt64, cap_len};
  wire logic [31:0] stat_rd = {27'h0, ovf_q, chg_q, pend_q, r_q, busy_q};
  wire logic [31:0] rd_mux =
    !adr_ok ? 32'h0 :
    (bus.adr == ADR_CTRL) ? ctrl_q :
    (bus.adr == ADR_CAP) ? cap_rd :
    (bus.adr == ADR_STAT) ? stat_rd :
    (bus.adr == ADR_LAST_LO) ? last_q[31:0] : 32'h0;

  // [RQ11] Gray conversion of sampled count
  assign gray_val = ts_count_i ^ (ts_count_i >> 1);
  // 48-bit format keeps only low 48 bits so compares ignore the rest
  assign samp = (gray_en ? gray_val : ts_count_i) & (fmt64 ? {TS_W{1'b1}} : {16'h0, {48{1'b1}}});
  // [RQ14] compare against last sent value
  assign diff = samp ^ last_q;
  assign nmax = fmt64 ? BYTES_64 : BYTES_48;

  always_comb
  begin
    top_bit = 7'h0;
    for (int i = 0; i < TS_W; i++)
    begin
      if (diff[i])
        top_bit = 7'(i + 1);
    end
  end

  // [RQ8] bytes to reach top changed bit
  // [RQ7] never fewer than one
  always_comb
  begin
    need = 4'h1;
    for (int k = 1; k < 9; k++)
    begin
      if (top_bit > 7'(7 * k))
        need = 4'(k + 1);
    end
    if (need > nmax)
      need = nmax;
  end

  // [RQ13] full after overflow
  // [RQ15] full request sends all
  wire logic go_full = pend_full_q | ovf_q;
  wire logic [3:0] n_pick = go_full ? nmax : need;
  wire logic start = en && (state_q == ST_IDLE) && pend_q && (!out_q.valid || out_ready_i);
  wire logic adv = !out_q.valid || out_ready_i;
  wire logic val_end = (idx_q + 4'h1) >= n_q;
  wire logic hdr_step = (state_q == ST_HDR) && adv;
  wire logic val_step = (state_q == ST_VAL) && adv;
  wire logic [7:0] hdr_byte = HDR_BASE | (8'(r_q) << HDR_R_BIT);

  tse_byte_sel u_sel (
    .val_i(val_q),
    .idx_i(idx_q),
    .n_i(n_q),
    .fmt64_i(fmt64),
    .byte_o(vbyte)
  );

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:
      begin
        if (start)
          state_d = ST_HDR;
      end
      ST_HDR:
      begin
        if (adv)
          state_d = ST_VAL;
      end
      ST_VAL:
      begin
        if (adv && val_end)
          state_d = ST_IDLE;
      end
    endcase
  end

  // Ack is registered, so every access costs one wait state; req masks ack_q
  // so a strobe held through the ack is not answered twice
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
    end
    else
    begin
      ack_q <= bus.req;
      if (bus.req)
        rdat_q <= rd_mux;
    end
  end

  // [RQ12] disabled after reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ctrl_q <= CTRL_RST;
    else if (wr_ctrl)
      ctrl_q <= (ctrl_q & ~sel_mask) | (bus.dat & sel_mask & 32'h1);
  end

  // Only format and Gray bits are writable; the length field is derived
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cap_q <= CAP_RST;
    else if (wr_cap)
      cap_q <= (cap_q & ~sel_mask) | (bus.dat & sel_mask & 32'h1000_0010);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= ST_IDLE;
      busy_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      busy_q <= (state_d != ST_IDLE);
    end
  end

  // Events arriving on the start edge stay pending; set beats clear
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pend_q <= 1'b0;
      pend_full_q <= 1'b0;
    end
    else
    begin
      pend_q <= en & ((pend_q & ~start) | ts_req_i | full_req_i | clk_change_i);
      pend_full_q <= en & ((pend_full_q & ~start) | full_req_i);
    end
  end

  // [RQ10] clock change recorded until next header
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      chg_q <= 1'b0;
      ovf_q <= 1'b0;
    end
    else
    begin
      chg_q <= (chg_q & ~start) | clk_change_i;
      ovf_q <= (ovf_q & ~start) | overflow_i;
    end
  end

  // [RQ14] sampled value becomes the compare base at packet start
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      val_q <= LAST_RST;
      last_q <= LAST_RST;
    end
    else if (start)
    begin
      // [RQ9] zero value passes through unchanged as unknown
      val_q <= samp;
      last_q <= samp;
    end
  end

  // Length and R are frozen at start, so late events wait for the next packet
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      n_q <= 4'h1;
      r_q <= 1'b0;
    end
    else if (start)
    begin
      n_q <= n_pick;
      r_q <= chg_q;
    end
  end

  // [RQ2] value bytes bounded by n_q
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      idx_q <= 4'h0;
    else if (start)
      idx_q <= 4'h0;
    else if (val_step)
      idx_q <= idx_q + 4'h1;
  end

  // Valid stays up until the sink takes the byte, so a stalled byte never moves
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      out_q <= '{data: 8'h00, valid: 1'b0, last: 1'b0};
    // [RQ1] header with clock-change flag
    else if (hdr_step)
      out_q <= '{data: hdr_byte, valid: 1'b1, last: 1'b0};
    else if (val_step)
      out_q <= '{data: vbyte, valid: 1'b1, last: val_end};
    else if (adv)
      out_q.valid <= 1'b0;
  end

  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;
  assign out_data_o = out_q.data;
  assign out_valid_o = out_q.valid;
  assign out_last_o = out_q.last;
  assign busy_o = busy_q;
endmodule

// ---- sim/tse_props.sv ----
// Purpose: stream and bus checks
// Assumes: one clock, sync reset
// Notes: h_q set while next byte is a header
`timescale 1ns/100ps
module tse_props
  import tse_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_ack_o, // Ack
  input wire logic out_ready_i, // Ready
  input wire logic [7:0] out_data_o, // Byte
  input wire logic out_valid_o, // Valid
  input wire logic out_last_o // Last
);
  logic h_q;
  logic [3:0] c_q;
  wire take = out_valid_o && out_ready_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      h_q <= 1'b1;
      c_q <= 4'h0;
    end
    else if (take)
    begin
      h_q <= out_last_o;
      c_q <= (h_q || out_last_o) ? 4'h0 : c_q + 4'h1;
    end
  end
  sequence s_hdr; out_valid_o && h_q; endsequence
  sequence s_val; out_valid_o && !h_q; endsequence
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  a_hdr_shape: assert property (s_hdr |-> (out_data_o & 8'hFB) == HDR_BASE)
    else $error("bad header");
  a_hdr_body: assert property (s_hdr |-> !out_last_o)
    else $error("header alone");
  a_cont_set: assert property (s_val ##0 !out_last_o |-> out_data_o[7])
    else $error("flag clear too early");
  a_cont_end: assert property (s_val ##0 (out_last_o && c_q < 4'h8) |-> !out_data_o[7])
    else $error("flag set on last");
  a_len_max: assert property (s_val ##0 c_q == 4'h8 |-> out_last_o)
    else $error("packet too long");
  a_byte_hold: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o))
    else $error("byte lost");
  a_ack_pulse: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack timing");
  a_ack_cause: assert property (wb_ack_o |-> $past(wb_stb_i))
    else $error("stray ack");
  a_quiet_reset: assert property ($fell(rst_i) |-> !out_valid_o [*4])
    else $error("output before enable");
endmodule

// ---- sim/tse_sink.sv ----
// Purpose: capture model that rebuilds sent values
// Assumes: ready registered, stall from the bench
// Notes: held upper bits stand for bytes not sent
`timescale 1ns/100ps
module tse_sink
  import tse_pkg::*;
(
  input wire logic clk_i, // Clock
  input wire logic rst_i, // Reset
  input wire logic stall_i, // Hold off
  input wire tse_pkg::tse_byte_t b_i, // Stream byte
  output logic ready_o, // Ready
  output logic [63:0] val_o // Rebuilt value
);
  logic hdr_q;
  logic [3:0] idx_q;
  wire take = b_i.valid && ready_o;
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ready_o <= 1'b0;
      hdr_q <= 1'b1;
      idx_q <= 4'h0;
      val_o <= 64'h0;
    end
    else
    begin
      ready_o <= !stall_i;
      if (take)
      begin
        hdr_q <= b_i.last;
        idx_q <= hdr_q ? 4'h0 : idx_q + 4'h1;
      end
      if (take && !hdr_q && idx_q == 4'h8)
        val_o[63:56] <= b_i.data;
      else if (take && !hdr_q)
        val_o[idx_q*7 +: 7] <= b_i.data[6:0];
    end
  end
endmodule

// ---- sim/tse_encoder_bench.sv ----
// Purpose: self-checking bench for tse_encoder
// Assumes: one packet in flight at a time
// Notes: count held steady until packet drains
`timescale 1ns/100ps
module tse_encoder_bench;
  import tse_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, we = 0, treq = 0, freq = 0, chg = 0, ovf = 0, stall = 0;
  logic [31:0] adr = 0, dat = 0, cap, seed = 32'hFE9CE037;
  logic [63:0] cnt = 0, last = 0;
  logic [8:0] sq[$];
  logic [31:0] rq[$];
  int n_mismatch = 0, n_tests = 0;
  wire ack, valid, lastb, rdy, busy;
  wire [7:0] data;
  wire [31:0] rdat;
  wire [63:0] rv;
  always #20 clk_i = ~clk_i;
  tse_encoder dut(.clk_i, .rst_i, .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(4'hF), .wb_we_i(we),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_dat_o(rdat), .wb_ack_o(ack), .ts_count_i(cnt), .ts_req_i(treq),
    .full_req_i(freq), .clk_change_i(chg), .overflow_i(ovf), .out_ready_i(rdy), .out_data_o(data),
    .out_valid_o(valid), .out_last_o(lastb), .busy_o(busy));
  tse_sink sink(.clk_i, .rst_i, .stall_i(stall), .b_i({data, valid, lastb}), .ready_o(rdy), .val_o(rv));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task finish_test;
    if (n_mismatch == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task tmo;
    n_mismatch++;
    finish_test;
  endtask
  always @(posedge clk_i)
  begin
    stall <= rnd() < 32'h4000_0000;
    if (valid && rdy)
      chk({lastb, data}, sq.size() ? sq.pop_front() : 'x); // stream
    if (ack && !we)
      chk(rdat, rq.pop_front()); // reads
  end
  task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    int t;
    @(posedge clk_i);
    adr <= a;
    we <= w;
    dat <= d;
    cyc <= 1'b1;
    for (t = 0; ack !== 1'b1 && t < 50; t++)
      @(posedge clk_i);
    if (t >= 50)
      tmo;
    cyc <= 1'b0;
  endtask
  task rd(input logic [31:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  task pkt(input int k);
    logic [63:0] v, e;
    int n, t;
    v = cnt + ({rnd(), rnd()} >> (k * 6));
    e = cap[CAP_GRAY_BIT] ? v ^ (v >> 1) : v;
    if (!cap[CAP_FMT64_BIT])
      e[63:48] = 16'h0;
    n = 1;
    for (int i = 0; i < 64; i++)
      if (e[i] !== last[i])
        n = i / 7 + 1;
    if (n > 7 + 2 * cap[CAP_FMT64_BIT] || k % 4 inside {1, 2})
      n = 7 + 2 * cap[CAP_FMT64_BIT];
    sq.push_back({1'b0, HDR_BASE | {5'h0, k % 4 == 3, 2'h0}});
    for (int i = 0; i < n; i++)
      sq.push_back(i == 8 ? {1'b1, e[63:56]} : {i == n - 1, i < n - 1, e[i*7 +: 7]});
    @(posedge clk_i);
    cnt <= v;
    treq <= k % 4 inside {0, 2};
    freq <= k % 4 == 1;
    ovf <= k % 4 == 2;
    chg <= k % 4 == 3;
    @(posedge clk_i);
    {treq, freq, ovf, chg} <= 4'h0;
    repeat (2) @(posedge clk_i);
    chk(busy, 1'b1); // busy while packet runs
    for (t = 0; sq.size() && t < 300; t++)
      @(posedge clk_i);
    if (t >= 300)
      tmo;
    @(posedge clk_i);
    chk(rv, e); // rebuilt value
    chk(busy, 1'b0); // idle after last byte
    last = e;
  endtask
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADR_CAP, {28'h0, PKT_LEN_48}); // reset format
    rd(32'h10, 32'h0); // unmapped reads zero
    rd(ADR_LAST_LO, 32'h0); // cleared copy
    rd(ADR_STAT, 32'h0); // idle status after reset
    treq <= 1'b1;
    @(posedge clk_i);
    treq <= 1'b0;
    repeat (20) @(posedge clk_i);
    bus(ADR_CTRL, 1'b1, 32'h1);
    for (int m = 0; m < 3; m++)
    begin
      cap = m == 0 ? 32'h0 : m == 1 ? 32'h10 : 32'h1000_0010;
      bus(ADR_CAP, 1'b1, cap);
      rd(ADR_CAP, cap | (m ? PKT_LEN_64 : PKT_LEN_48)); // length field
      for (int k = 0; k < 13; k++)
        pkt(k);
      rd(ADR_LAST_LO, last[31:0]); // last copy
    end
    finish_test;
  end
endmodule
bind tse_encoder tse_props u_props(.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .out_ready_i,
  .out_data_o, .out_valid_o, .out_last_o);
